/* File: logic/sba_arbiter.sv */
`timescale 1ns/1ns
// What this block does
// (R1) nine active-low requests, one slot each
// (R2) bridge request is an internal input
// (R3) each request selectable high or low group
// (R4) masters hold request low to want bus
// (R5) nine active-low grants, at most one asserted
// (R6) granted master starts only on idle bus
// (R7) bridge grant is an internal output
// (R8) two-level rotating priority picks the winner
// (R9) strap low enables arbiter, high disables it
// (R10) external mode: request pin 0 is grant in
// (R11) external mode: start only granted and idle
// (R12) external mode: grant pin 0 is request out
// (R13) external mode: park when granted, idle, no work
// (R14) sample inputs, drive grants on clock rise
// (R15) low group is one slot; rotate past winner
// (R16) reset: all high group, pointers on last slot
module sba_arbiter (
   clk,
   rst,
   req_n_pin,
   central_fn_n_pin,
   bus_idle,
   bridge_req,
   group_high,
   bridge_group_high,
   gnt_n_pin,
   gnt_oe_n,
   bridge_gnt,
   bridge_start_ok,
   bridge_park,
   arb_enabled
);
   input wire logic clk;
   input wire logic rst;
   input wire logic [sba_pkg::NUM_EXT-1:0] req_n_pin;
   input wire logic central_fn_n_pin;
   input wire logic bus_idle;
   input wire logic bridge_req;
   input wire logic [sba_pkg::NUM_EXT-1:0] group_high;
   input wire logic bridge_group_high;
   output logic [sba_pkg::NUM_EXT-1:0] gnt_n_pin;
   output logic [sba_pkg::NUM_EXT-1:0] gnt_oe_n;
   output logic bridge_gnt;
   output logic bridge_start_ok;
   output logic bridge_park;
   output logic arb_enabled;

   localparam int NE = sba_pkg::NUM_EXT;
   localparam int NL = sba_pkg::NUM_EXT + 1;
   localparam int NH = sba_pkg::NUM_HI_SLOTS;
   localparam int WL = $clog2(NL);
   localparam int WH = $clog2(NH);

   logic [NE-1:0] req_n_s;
   logic cfn_n_s;
   logic [NE-1:0] req_act;
   logic [NE-1:0] grp_hi_q;
   logic bgrp_hi_q;
   logic [NL-1:0] all_req;
   logic [NL-1:0] all_hi;
   logic [NH-1:0] hi_req;
   logic [NL-1:0] lo_req;
   logic hi_found;
   logic lo_found;
   logic [WH-1:0] hi_pick;
   logic [WL-1:0] lo_pick;
   logic [WH-1:0] hi_last_q;
   logic [WL-1:0] lo_last_q;
   logic [NL-1:0] win_d;
   logic [NL-1:0] win_q;
   logic win_valid;
   logic [WL-1:0] win_idx;
   logic ext_mode;
   logic ext_gnt;
   logic idle_q;
   logic bridge_req_q;
   sba_pkg::sba_state_t state_q;
   sba_pkg::sba_state_t state_d;

   // two-flop synchronisers on pin requests and the strap [R14]
   sba_sync #(.WIDTH(NE), .RST_VAL({NE{1'b1}})) u_req_sync (
      .clk(clk),
      .rst(rst),
      .din(req_n_pin),
      .dout(req_n_s)
   );
   sba_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_cfn_sync (
      .clk(clk),
      .rst(rst),
      .din(central_fn_n_pin),
      .dout(cfn_n_s)
   );

   // strap high turns the internal arbiter off [R9]
   assign ext_mode = cfn_n_s;
   // low level means a master wants the bus [R1] [R4]
   assign req_act = ~req_n_s;
   // in external mode pin 0 carries the grant from outside [R10]
   assign ext_gnt = req_act[sba_pkg::PIN_REUSE];

   // registered group selects; reset puts everyone high [R3] [R16]
   always_ff @(posedge clk) begin
      if (rst) begin
         grp_hi_q <= sba_pkg::GROUP_RST;
         bgrp_hi_q <= sba_pkg::BRIDGE_GROUP_RST;
      end else begin
         grp_hi_q <= group_high;
         bgrp_hi_q <= bridge_group_high;
      end
   end

   // register idle and bridge request on the clock edge [R14]
   always_ff @(posedge clk) begin
      if (rst) begin
         idle_q <= 1'b0;
         bridge_req_q <= 1'b0;
      end else begin
         idle_q <= bus_idle;
         bridge_req_q <= bridge_req;
      end
   end

   // bridge request joins as slot nine, internally [R2]
   assign all_req = {bridge_req_q, req_act};
   assign all_hi = {bgrp_hi_q, grp_hi_q};
   assign lo_req = all_req & ~all_hi;
   // low group takes one slot of the high ring [R15]
   assign hi_req = {(|lo_req), all_req & all_hi};

   // two rotating rings, high then low [R8]
   sba_rr #(.N(NH)) u_hi_rr (
      .req(hi_req),
      .last(hi_last_q),
      .found(hi_found),
      .pick(hi_pick)
   );
   sba_rr #(.N(NL)) u_lo_rr (
      .req(lo_req),
      .last(lo_last_q),
      .found(lo_found),
      .pick(lo_pick)
   );

   // resolve the two-level pick to a slot number [R8]
   always_comb begin
      win_valid = hi_found;
      win_idx = WL'(hi_pick);
      if (hi_found && hi_pick == WH'(sba_pkg::SLOT_LOW)) begin
         win_valid = lo_found;
         win_idx = lo_pick;
      end
   end

   // one-hot grant vector, at most one bit [R5]
   always_comb begin
      win_d = '0;
      if (win_valid) begin
         win_d[win_idx] = 1'b1;
      end
   end

   // state: idle -> grant -> busy while bus is used
   always_comb begin
      state_d = state_q;
      case (state_q)
         sba_pkg::SBA_IDLE: begin
            if (!ext_mode && win_valid) begin
               state_d = sba_pkg::SBA_GRANT;
            end
         end
         sba_pkg::SBA_GRANT: begin
            // winner starts only once bus is idle and then taken [R6]
            if (ext_mode) begin
               state_d = sba_pkg::SBA_IDLE;
            end else if (!idle_q) begin
               state_d = sba_pkg::SBA_BUSY;
            end else if (!(|(win_q & all_req))) begin
               state_d = sba_pkg::SBA_IDLE;
            end
         end
         sba_pkg::SBA_BUSY: begin
            if (idle_q || ext_mode) begin
               state_d = sba_pkg::SBA_IDLE;
            end
         end
         default: state_d = sba_pkg::SBA_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= sba_pkg::SBA_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // held grant; park on the bridge when nobody asks [R5] [R14]
   always_ff @(posedge clk) begin
      if (rst || ext_mode) begin
         win_q <= '0;
      end else if (state_q == sba_pkg::SBA_IDLE) begin
         if (win_valid) begin
            win_q <= win_d;
         end else begin
            win_q <= '0;
            win_q[sba_pkg::SLOT_BRIDGE] <= 1'b1;
         end
      end else if (state_q == sba_pkg::SBA_GRANT && state_d == sba_pkg::SBA_IDLE) begin
         win_q <= '0;
      end
   end

   // rotate past each winner once granted; reset points at the last slot [R15] [R16]
   always_ff @(posedge clk) begin
      if (rst) begin
         hi_last_q <= WH'(NH - 1);
         lo_last_q <= WL'(NL - 1);
      end else if (!ext_mode && state_q == sba_pkg::SBA_IDLE && win_valid) begin
         hi_last_q <= hi_pick;
         if (hi_pick == WH'(sba_pkg::SLOT_LOW)) begin
            lo_last_q <= lo_pick;
         end
      end
   end

   // grant pins, bridge grant and external-mode request [R7] [R12] [R14]
   always_ff @(posedge clk) begin
      if (rst) begin
         gnt_n_pin <= '1;
         gnt_oe_n <= '1;
         bridge_gnt <= 1'b0;
         arb_enabled <= 1'b0;
      end else if (ext_mode) begin
         gnt_n_pin <= '1;
         gnt_n_pin[sba_pkg::PIN_REUSE] <= ~bridge_req_q;
         gnt_oe_n <= '1;
         gnt_oe_n[sba_pkg::PIN_REUSE] <= 1'b0;
         bridge_gnt <= ext_gnt;
         arb_enabled <= 1'b0;
      end else begin
         gnt_n_pin <= ~win_q[NE-1:0];
         gnt_oe_n <= '0;
         bridge_gnt <= win_q[sba_pkg::SLOT_BRIDGE];
         arb_enabled <= 1'b1;
      end
   end

   // start permission and parking indication [R11] [R13]
   always_ff @(posedge clk) begin
      if (rst) begin
         bridge_start_ok <= 1'b0;
         bridge_park <= 1'b0;
      end else if (ext_mode) begin
         bridge_start_ok <= ext_gnt && idle_q && bridge_req_q;
         bridge_park <= ext_gnt && idle_q && !bridge_req_q;
      end else begin
         bridge_start_ok <= win_q[sba_pkg::SLOT_BRIDGE] && idle_q && bridge_req_q;
         bridge_park <= win_q[sba_pkg::SLOT_BRIDGE] && idle_q && !bridge_req_q;
      end
   end

   // never two grant pins low together
   a_one_grant: assert property (@(posedge clk) disable iff (rst)
      $onehot0(~gnt_n_pin)) else $error("more than one grant asserted"); // [R5]

   // grant follows winner two edges later in internal mode
   sequence s_internal_win;
      !ext_mode && state_q == sba_pkg::SBA_IDLE && win_valid && win_idx < WL'(NE);
   endsequence
   a_grant_follows: assert property (@(posedge clk) disable iff (rst)
      s_internal_win ##1 !ext_mode |=> gnt_n_pin[$past(win_idx, 2)] == 1'b0)
      else $error("winner not granted"); // [R8]

   // external mode drives pin 0 as inverted bridge request
   a_ext_req_out: assert property (@(posedge clk) disable iff (rst)
      ext_mode |=> gnt_n_pin[0] == ~$past(bridge_req_q) && gnt_oe_n[0] == 1'b0)
      else $error("request out wrong in external mode"); // [R12]

   // no start without outside grant and idle bus
   a_ext_start: assert property (@(posedge clk) disable iff (rst)
      ext_mode && !(ext_gnt && idle_q) |=> !bridge_start_ok)
      else $error("start without external grant"); // [R11]

   // parking only without pending work
   a_park_cond: assert property (@(posedge clk) disable iff (rst)
      bridge_park |-> !bridge_start_ok) else $error("park while starting"); // [R13]

   // bridge grant never on a pin in internal mode
   a_bridge_internal: assert property (@(posedge clk) disable iff (rst)
      arb_enabled && bridge_gnt |-> &gnt_n_pin) else $error("bridge grant on a pin"); // [R7]

   // rotation moves the pointer to the winner
   a_rotate_ptr: assert property (@(posedge clk) disable iff (rst)
      !ext_mode && state_q == sba_pkg::SBA_IDLE && win_valid |=> hi_last_q == $past(hi_pick))
      else $error("rotation did not advance"); // [R15]

   // strap high leaves grants 8..1 released
   a_ext_released: assert property (@(posedge clk) disable iff (rst)
      ext_mode |=> &gnt_oe_n[NE-1:1] && !arb_enabled) else $error("grants driven while disabled"); // [R9]
endmodule // sba_arbiter

/* File: inc/sba_pkg.sv */
package sba_pkg;
   // number of external request/grant pairs
   localparam int NUM_EXT = 9;
   // slot index of the bridge's own request inside the high rotation
   localparam int SLOT_BRIDGE = 9;
   // slot index standing for the whole low group inside the high rotation
   localparam int SLOT_LOW = 10;
   // number of slots in the high rotation (9 external, bridge, low group)
   localparam int NUM_HI_SLOTS = 11;
   // reset value of the group selects: every request in the high group
   localparam logic [8:0] GROUP_RST = 9'h1ff;
   // reset value of the bridge's own group select (high)
   localparam logic BRIDGE_GROUP_RST = 1'b1;
   // pin index reused in external-arbiter mode
   localparam int PIN_REUSE = 0;
   // arbiter states
   typedef enum logic [1:0] {
      SBA_IDLE = 2'b00,
      SBA_GRANT = 2'b01,
      SBA_BUSY = 2'b10
   } sba_state_t;
endpackage

/* File: logic/sba_sync.sv */
`timescale 1ns/1ns
// two-flop synchroniser for a vector of pin inputs
module sba_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule // sba_sync

/* File: logic/sba_rr.sv */
`timescale 1ns/1ns
// round-robin pick: first requester strictly after the last winner
module sba_rr #(
   parameter int N = 4
) (
   input wire logic [N-1:0] req,
   input wire logic [$clog2(N)-1:0] last,
   output logic found,
   output logic [$clog2(N)-1:0] pick
);
   localparam int W = $clog2(N);

   // refuse a ring too small to rotate
   if (N < 2) begin : g_bad_n
      $error("sba_rr needs at least two slots");
   end

   // scan from last+1 around the ring, first hit wins
   always_comb begin
      int idx;
      idx = 0;
      found = 1'b0;
      pick = '0;
      for (int k = 1; k <= N; k++) begin
         idx = (int'(last) + k) % N;
         if (!found && req[idx]) begin
            found = 1'b1;
            pick = W'(idx);
         end
      end
   end
endmodule // sba_rr

/* File: testbench/sba_master_model.sv */
`timescale 1ns/1ns
// far side: nine bus masters, or the external arbiter on pin 0
module sba_master_model (
   input wire logic clk,
   input wire logic ext_mode,
   input wire logic ext_grant,
   input wire logic [8:0] set_req,
   input wire logic [8:0] gnt_n_pin,
   output logic [8:0] req_n_pin,
   output logic bus_idle
);
   logic [8:0] want_q = 9'h000;
   logic [8:0] clr;
   int busy_cnt = 0;
   // a granted master starts only on an idle bus
   always_comb begin
      clr = 9'h000;
      for (int i = 0; i < 9; i++) begin
         if (busy_cnt == 0 && !ext_mode && gnt_n_pin[i] === 1'b0 && want_q[i]) begin
            clr[i] = 1'b1;
         end
      end
   end
   // request kept until its transaction starts; bus busy for three cycles
   always @(negedge clk) begin
      want_q <= (want_q | set_req) & ~clr;
      if (clr != 9'h000) begin
         busy_cnt <= 3;
      end else if (busy_cnt != 0) begin
         busy_cnt <= busy_cnt - 1;
      end
   end
   // requests low while wanted; bit 0 carries the grant in external mode
   assign req_n_pin = ext_mode ? {~want_q[8:1], ~ext_grant} : ~want_q;
   assign bus_idle = (busy_cnt == 0);
endmodule // sba_master_model

/* File: testbench/sba_arbiter_tb_top.sv */
`timescale 1ns/1ns
// self-checking bench for the secondary bus arbiter
module sba_arbiter_tb_top;
   logic clk, rst, central_fn_n_pin, bridge_req, bridge_group_high, ext_grant, bus_idle;
   logic bridge_gnt, bridge_start_ok, bridge_park, arb_enabled;
   logic [8:0] req_n_pin, group_high, set_req, gnt_n_pin, gnt_oe_n;
   int n_errors = 0;
   int samples_checked = 0;
   sba_arbiter sba_arbiter_inst (.clk(clk), .rst(rst), .req_n_pin(req_n_pin),
      .central_fn_n_pin(central_fn_n_pin), .bus_idle(bus_idle), .bridge_req(bridge_req),
      .group_high(group_high), .bridge_group_high(bridge_group_high), .gnt_n_pin(gnt_n_pin),
      .gnt_oe_n(gnt_oe_n), .bridge_gnt(bridge_gnt), .bridge_start_ok(bridge_start_ok),
      .bridge_park(bridge_park), .arb_enabled(arb_enabled));
   sba_master_model sba_master_model_inst (.clk(clk), .ext_mode(central_fn_n_pin),
      .ext_grant(ext_grant), .set_req(set_req), .gnt_n_pin(gnt_n_pin),
      .req_n_pin(req_n_pin), .bus_idle(bus_idle));
   // 40 ns clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // compare and count
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // verdict and end of run
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // wait for a grant other than the previous one
   task automatic wait_new(input logic [8:0] prev);
      for (int k = 0; k < 60 && (gnt_n_pin === 9'h1ff || gnt_n_pin === prev); k++) @(negedge clk);
   endtask
   // several masters at once; grants must follow the given order, one nibble per grant
   task automatic run_order(input logic [8:0] reqs, input logic [35:0] order, input int cnt);
      logic [8:0] prev;
      prev = 9'h1ff;
      set_req <= reqs;
      @(negedge clk);
      set_req <= 9'h000;
      for (int g = 0; g < cnt; g++) begin
         wait_new(prev);
         check(gnt_n_pin, ~(9'h001 << order[4*g +: 4]));
         prev = gnt_n_pin;
      end
      repeat (12) @(negedge clk);
   endtask
   // reset state and the bridge's own request in internal mode
   task automatic test_reset_bridge();
      check(gnt_n_pin, 9'h1ff);
      check(gnt_oe_n, 9'h000);
      check({8'h00, arb_enabled}, 9'h001);
      bridge_req <= 1'b1;
      for (int k = 0; k < 20 && bridge_start_ok !== 1'b1; k++) @(negedge clk);
      check({8'h00, bridge_start_ok}, 9'h001);
      check({8'h00, bridge_gnt}, 9'h001);
      check(gnt_n_pin, 9'h1ff);
      bridge_req <= 1'b0;
      repeat (6) @(negedge clk);
      $display("test_reset_bridge done");
   endtask
   // all nine in the high group: slot 0 first, then in turn
   task automatic test_rotation();
      run_order(9'h1ff, 36'h876543210, 9);
      $display("test_rotation done");
   endtask
   // masters 1 and 2 low: low group takes one high slot per round
   task automatic test_groups();
      group_high <= 9'h1f9;
      repeat (3) @(negedge clk);
      run_order(9'h036, 36'h000002541, 4);
      $display("test_groups done");
   endtask
   // strap high: pin 0 pair goes to the external arbiter
   task automatic test_external();
      central_fn_n_pin <= 1'b1;
      repeat (6) @(negedge clk);
      check({8'h00, arb_enabled}, 9'h000);
      check(gnt_oe_n, 9'h1fe);
      check(gnt_n_pin, 9'h1ff);
      bridge_req <= 1'b1;
      repeat (3) @(negedge clk);
      check(gnt_n_pin, 9'h1fe);
      check({8'h00, bridge_start_ok}, 9'h000);
      ext_grant <= 1'b1;
      repeat (4) @(negedge clk);
      check({8'h00, bridge_start_ok}, 9'h001);
      bridge_req <= 1'b0;
      repeat (3) @(negedge clk);
      check(gnt_n_pin, 9'h1ff);
      check({7'h00, bridge_park, bridge_start_ok}, 9'h002);
      ext_grant <= 1'b0;
      repeat (4) @(negedge clk);
      check({8'h00, bridge_park}, 9'h000);
      $display("test_external done");
   endtask
   // main sequence
   initial begin
      rst = 1'b1;
      central_fn_n_pin = 1'b0;
      bridge_req = 1'b0;
      bridge_group_high = 1'b1;
      ext_grant = 1'b0;
      group_high = 9'h1ff;
      set_req = 9'h000;
      repeat (16) @(negedge clk);
      rst <= 1'b0;
      repeat (6) @(negedge clk);
      test_reset_bridge();
      test_rotation();
      test_groups();
      test_external();
      end_of_test();
   end
   // hang guard, well beyond the few hundred cycles of the tests
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      $display("watchdog expired");
      end_of_test();
   end
endmodule // sba_arbiter_tb_top
